// ==== logic/tos_pkg.sv ====
package tos_pkg;

  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int         PORTS     = 8;
  localparam int         CHANS     = 32;
  localparam logic [4:0] T1_CHANS  = 5'h18;
  localparam logic [4:0] SLC_BITS  = 5'h18;
  localparam logic [1:0] ADDR_TOP  = 2'h0;

  // ************************************************************
  // Register indexes inside one port window of 0x200 indexes
  // ************************************************************
  localparam logic [8:0] OFS_IDLE_CODE = 9'h100;
  localparam logic [8:0] OFS_INS_EN    = 9'h150;
  localparam logic [8:0] OFS_FW_REV    = 9'h160;
  localparam logic [8:0] OFS_FDL       = 9'h162;
  localparam logic [8:0] OFS_BOC       = 9'h163;
  localparam logic [8:0] OFS_LINK1     = 9'h164;
  localparam logic [8:0] OFS_LINK2     = 9'h165;
  localparam logic [8:0] OFS_LINK3     = 9'h166;
  localparam logic [8:0] OFS_SI_ODD    = 9'h167;
  localparam logic [8:0] OFS_RA        = 9'h168;
  localparam logic [8:0] OFS_SA4       = 9'h169;
  localparam logic [8:0] OFS_LINE_CTRL = 9'h170;

  // ************************************************************
  // Values after reset and fixed field contents
  // ************************************************************
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_ALIGN     = 8'h1B;
  localparam logic [7:0] RST_NONALIGN  = 8'h40;
  // The revision value is arbitrary.
  localparam logic [7:0] FW_REV        = 8'h01;
  localparam logic [7:0] BOC_MASK      = 8'h3F;
  localparam logic [7:0] D4_FDL_MASK   = 8'h3F;
  localparam logic [2:0] FDL_LAST      = 3'h7;
  localparam logic [2:0] D4_FDL_LAST   = 3'h5;
  localparam logic [7:0] SLC2_FIX_MASK = 8'h38;
  localparam logic [7:0] SLC2_FIX_VAL  = 8'h10;
  localparam logic [7:0] SLC3_FIX_MASK = 8'h80;
  localparam logic [7:0] SLC3_FIX_VAL  = 8'h80;
  localparam logic [7:0] NAF_FIX_MASK  = 8'h40;
  localparam logic [7:0] CTRL_WR_MASK  = 8'h3F;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    FRM_ESF   = 2'b00,
    FRM_D4    = 2'b01,
    FRM_SLC96 = 2'b10,
    FRM_RSVD  = 2'b11
  } tos_framing_t;

  typedef enum logic [1:0] {
    OH_FDL = 2'b00,
    OH_BOC = 2'b01,
    OH_SLC = 2'b10,
    OH_E1  = 2'b11
  } tos_oh_kind_t;

  typedef struct packed {
    logic [1:0]   spare;
    logic         sa4_per_frame;
    logic         ra_per_frame;
    logic         si_per_frame;
    tos_framing_t framing;
    logic         e1;
  } tos_ctrl_t;

  typedef struct packed {
    logic [31:0] ins_en;
    tos_ctrl_t   ctrl;
    logic [7:0]  fdl;
    logic [7:0]  boc;
    logic [7:0]  slc1;
    logic [7:0]  slc2;
    logic [7:0]  slc3;
    logic [7:0]  af;
    logic [7:0]  naf;
    logic [7:0]  si_even;
    logic [7:0]  si_odd;
    logic [7:0]  ra;
    logic [7:0]  sa4;
  } tos_port_regs_t;

  typedef struct packed {
    logic [2:0] port;
    logic [4:0] num;
    logic [7:0] data;
  } tos_chan_t;

  typedef struct packed {
    tos_oh_kind_t kind;
    logic [2:0]   port;
    logic [4:0]   idx;
  } tos_oh_req_t;

  localparam tos_port_regs_t PORT_REGS_RST = '{
    ins_en:  32'h0000_0000,
    ctrl:    8'h00,
    fdl:     RST_ZERO,
    boc:     RST_ZERO,
    slc1:    RST_ZERO,
    slc2:    RST_ZERO,
    slc3:    RST_ZERO,
    af:      RST_ALIGN,
    naf:     RST_NONALIGN,
    si_even: RST_ZERO,
    si_odd:  RST_ZERO,
    ra:      RST_ZERO,
    sa4:     RST_ZERO
  };

endpackage : tos_pkg

// ==== logic/tos_tx_overhead.sv ====
`timescale 1ns/1ns

// Overview of operation
// RULE1 - Channels with insert bit set take the idle code, others pass unchanged.
// RULE2 - Insert bits cover 24 channels in T1 and 32 channels in E1.
// RULE3 - An 8-bit read-only firmware revision is readable; writes leave it.
// RULE4 - In T1 outside D4 framing the data link byte is taken whole from its register and sent.
// RULE5 - Data link bytes are sent least significant bit first.
// RULE6 - In D4 framing only the lower six data link bits are used.
// RULE7 - In D4 framing the data link register supplies the Fs pattern bits.
// RULE8 - Bit-oriented code is six bits wide; bits 7 and 6 are unused.
// RULE9 - Every register repeats per port, eight ports, at a stride of 0x200.
// RULE10 - Three SLC addresses become align, non-align and Si registers in E1.
// RULE11 - Align word has Si in bit 7 and pattern 0011011 by default below.
// RULE12 - Non-align word has Si in bit 7 and a fixed one in bit 6.
// RULE13 - Non-align word bit 5 is sent as the remote alarm bit.
// RULE14 - Sa4 to Sa8 sit in non-align word bits 4 down to 0.
// RULE15 - Si of even frame 2k comes from bit k of one register.
// RULE16 - Si of odd frame 2k+1 comes from bit k of one register.
// RULE17 - Remote alarm of odd frame 2k+1 comes from bit k of one register.
// RULE18 - Sa4 of odd frame 2k+1 comes from bit k of one register.
// RULE19 - SLC registers give C, M, A and S bits with fixed S positions forced.
// RULE20 - Software loads all overhead registers before the framer is enabled.
module tos_tx_overhead
  import tos_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [15:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  input  wire logic        CH_IN_VALID,
  input  wire tos_chan_t   CH_IN,
  output logic             CH_OUT_VALID,
  output tos_chan_t        CH_OUT,
  input  wire logic        OH_REQ_VALID,
  input  wire tos_oh_req_t OH_REQ,
  output logic             OH_ACK,
  output logic [7:0]       OH_DATA
);

  // ************************************************************
  // Storage
  // ************************************************************
  tos_port_regs_t regs      [PORTS];
  logic [7:0]     idle_code [PORTS][CHANS];

  // Each port owns its own serialiser.
  logic [7:0]     fdl_sh    [PORTS];
  logic [2:0]     fdl_cnt   [PORTS];
  logic [7:0]     fdl_load  [PORTS];
  logic           fdl_bit   [PORTS];

  // Fixed switching bits win over written values.
  function automatic logic [7:0] fix_slc2(input logic [7:0] v);
    fix_slc2 = (v & ~SLC2_FIX_MASK) | SLC2_FIX_VAL;
  endfunction : fix_slc2

  function automatic logic [7:0] fix_slc3(input logic [7:0] v);
    fix_slc3 = (v & ~SLC3_FIX_MASK) | SLC3_FIX_VAL;
  endfunction : fix_slc3

  // ************************************************************
  // APB decode
  // ************************************************************
  logic [2:0]     sel_port;
  logic [8:0]     reg_ofs;
  tos_port_regs_t sel_regs;
  logic           sel_e1;

  logic           hit_idle;
  logic           hit_en;
  logic           hit_fw;
  logic           hit_fdl;
  logic           hit_boc;

  logic           hit_link1;
  logic           hit_link2;
  logic           hit_link3;

  logic           hit_si_odd;
  logic           hit_ra;
  logic           hit_sa4;
  logic           hit_ctrl;

  logic           addr_ok;
  logic           apb_access;
  logic           apb_wr_fire;
  logic           next_pready;

  // Port index sits above the nine-bit register index.
  assign sel_port    = PADDR[13:11]; // see RULE9
  assign reg_ofs     = PADDR[10:2];
  assign sel_regs    = regs[sel_port];
  assign sel_e1      = sel_regs.ctrl.e1;
  assign hit_idle    = reg_ofs[8:5] == OFS_IDLE_CODE[8:5];
  assign hit_en      = reg_ofs[8:2] == OFS_INS_EN[8:2];
  assign hit_fw      = reg_ofs == OFS_FW_REV;
  assign hit_fdl     = reg_ofs == OFS_FDL;
  assign hit_boc     = reg_ofs == OFS_BOC;
  assign hit_link1   = reg_ofs == OFS_LINK1;
  assign hit_link2   = reg_ofs == OFS_LINK2;
  assign hit_link3   = reg_ofs == OFS_LINK3;
  assign hit_si_odd  = reg_ofs == OFS_SI_ODD;
  assign hit_ra      = reg_ofs == OFS_RA;
  assign hit_sa4     = reg_ofs == OFS_SA4;
  assign hit_ctrl    = reg_ofs == OFS_LINE_CTRL;
  assign addr_ok     = (PADDR[15:14] == ADDR_TOP) &&
                       (hit_idle | hit_en | hit_fw | hit_fdl | hit_boc |
                        hit_link1 | hit_link2 | hit_link3 | hit_si_odd |
                        hit_ra | hit_sa4 | hit_ctrl);
  assign apb_access  = PSEL && PENABLE;
  // A write lands on the same edge at which the master sees PREADY high.
  assign apb_wr_fire = apb_access && PREADY && PWRITE && addr_ok;
  // Access phase always lasts two cycles, with one wait state.
  assign next_pready = apb_access && !PREADY;

  // ************************************************************
  // Read view
  // ************************************************************
  logic [7:0] rd_link1;
  logic [7:0] rd_link2;
  logic [7:0] rd_link3;

  logic [7:0] rd_data;

  // The shared addresses show the view of the current line mode.
  assign rd_link1 = sel_e1 ? sel_regs.af : sel_regs.slc1; // see RULE10
  assign rd_link2 = sel_e1 ? (sel_regs.naf | NAF_FIX_MASK) // see RULE12
                           : fix_slc2(sel_regs.slc2); // see RULE19
  assign rd_link3 = sel_e1 ? sel_regs.si_even : fix_slc3(sel_regs.slc3);
  assign rd_data  =
    hit_idle   ? idle_code[sel_port][reg_ofs[4:0]] :
    hit_en     ? sel_regs.ins_en[{reg_ofs[1:0], 3'b000} +: 8] :
    hit_fw     ? FW_REV : // see RULE3
    hit_fdl    ? sel_regs.fdl :
    hit_boc    ? sel_regs.boc :
    hit_link1  ? rd_link1 :
    hit_link2  ? rd_link2 :
    hit_link3  ? rd_link3 :
    hit_si_odd ? sel_regs.si_odd :
    hit_ra     ? sel_regs.ra :
    hit_sa4    ? sel_regs.sa4 :
    hit_ctrl   ? sel_regs.ctrl :
                 RST_ZERO;

  // ************************************************************
  // Write view
  // ************************************************************
  tos_port_regs_t next_regs;
  logic [7:0]     wdata;

  assign wdata = PWDATA[7:0];

  // Only the addressed field changes.
  always_comb begin
    next_regs = sel_regs;
    if (hit_en) begin
      next_regs.ins_en[{reg_ofs[1:0], 3'b000} +: 8] = wdata;
    end
    if (hit_fdl) begin
      next_regs.fdl = wdata;
    end
    if (hit_boc) begin
      next_regs.boc = wdata & BOC_MASK; // see RULE8
    end
    if (hit_link1) begin
      if (sel_e1) begin
        next_regs.af = wdata; // see RULE11
      end else begin
        next_regs.slc1 = wdata;
      end
    end
    if (hit_link2) begin
      if (sel_e1) begin
        next_regs.naf = wdata | NAF_FIX_MASK; // see RULE12
      end else begin
        next_regs.slc2 = wdata;
      end
    end
    if (hit_link3) begin
      if (sel_e1) begin
        next_regs.si_even = wdata; // see RULE10
      end else begin
        next_regs.slc3 = wdata;
      end
    end
    if (hit_si_odd) begin
      next_regs.si_odd = wdata;
    end
    if (hit_ra) begin
      next_regs.ra = wdata;
    end
    if (hit_sa4) begin
      next_regs.sa4 = wdata;
    end
    if (hit_ctrl) begin
      next_regs.ctrl = tos_ctrl_t'(wdata & CTRL_WR_MASK);
    end
  end

  // ************************************************************
  // Per-port storage and data link serialiser
  // ************************************************************
  for (genvar g = 0; g < PORTS; g++) begin : g_port
    logic wr_here;
    logic fdl_take;
    logic is_d4;

    assign wr_here  = apb_wr_fire && (sel_port == 3'(g)); // see RULE9
    assign is_d4    = regs[g].ctrl.framing == FRM_D4;
    // D4 uses only six bits; they also carry the Fs pattern.
    assign fdl_load[g] = is_d4 ? (regs[g].fdl & D4_FDL_MASK) // see RULE6
                               : regs[g].fdl; // see RULE4
    // In E1 the serialiser holds its place.
    assign fdl_take = OH_REQ_VALID && (OH_REQ.kind == OH_FDL) &&
                      (OH_REQ.port == 3'(g)) && !regs[g].ctrl.e1; // see RULE4
    assign fdl_bit[g] = (fdl_cnt[g] == 3'h0) ? fdl_load[g][0] // see RULE5
                                             : fdl_sh[g][0];

    always_ff @(posedge REF_CLK) begin
      if (SRST) begin
        regs[g] <= PORT_REGS_RST;
      end else if (wr_here) begin
        regs[g] <= next_regs;
      end
    end

    // Idle codes are reset so a channel enabled early sends zeros, not junk.
    always_ff @(posedge REF_CLK) begin
      if (SRST) begin
        for (int c = 0; c < CHANS; c++) begin
          idle_code[g][c] <= RST_ZERO;
        end
      end else if (wr_here && hit_idle) begin
        idle_code[g][reg_ofs[4:0]] <= wdata;
      end
    end

    // A new byte is taken only when the previous one is fully sent.
    // Framing is read at load, so a change waits a byte.
    always_ff @(posedge REF_CLK) begin
      if (SRST) begin
        fdl_sh[g]  <= RST_ZERO;
        fdl_cnt[g] <= 3'h0;
      end else if (fdl_take) begin
        if (fdl_cnt[g] == 3'h0) begin
          fdl_sh[g]  <= fdl_load[g] >> 1; // see RULE4
          fdl_cnt[g] <= is_d4 ? D4_FDL_LAST : FDL_LAST; // see RULE6
        end else begin
          fdl_sh[g]  <= fdl_sh[g] >> 1; // see RULE5
          fdl_cnt[g] <= fdl_cnt[g] - 3'h1;
        end
      end
    end
  end

  // ************************************************************
  // Idle code insertion
  // ************************************************************
  tos_port_regs_t ch_regs;
  logic           ch_in_range;
  logic           ch_insert;

  tos_chan_t      next_ch;

  // Channel number zero is channel one.
  assign ch_regs     = regs[CH_IN.port];
  assign ch_in_range = ch_regs.ctrl.e1 || (CH_IN.num < T1_CHANS); // see RULE2
  assign ch_insert   = ch_regs.ins_en[CH_IN.num] && ch_in_range;
  assign next_ch     = '{port: CH_IN.port,
                         num:  CH_IN.num,
                         data: ch_insert ? idle_code[CH_IN.port][CH_IN.num] // see RULE1
                                         : CH_IN.data};

  // ************************************************************
  // Overhead sources
  // ************************************************************
  tos_port_regs_t oh_regs;

  logic [3:0]     oh_frame;
  logic [2:0]     oh_pair;
  logic           oh_e1;

  logic           e1_si_even;
  logic           e1_si_odd;
  logic           e1_alarm;
  logic           e1_sa4;
  logic [7:0]     e1_word;

  logic [23:0]    slc_vec;
  logic           slc_bit;

  logic [7:0]     next_oh_data;

  assign oh_regs  = regs[OH_REQ.port];
  assign oh_frame = OH_REQ.idx[3:0];
  // Both frames of a pair use the same bit index of their per-frame registers.
  assign oh_pair  = oh_frame[3:1];
  assign oh_e1    = oh_regs.ctrl.e1;

  assign e1_si_even = oh_regs.ctrl.si_per_frame ? oh_regs.si_even[oh_pair] // see RULE15
                                                : oh_regs.af[7]; // see RULE11
  assign e1_si_odd  = oh_regs.ctrl.si_per_frame ? oh_regs.si_odd[oh_pair] // see RULE16
                                                : oh_regs.naf[7]; // see RULE12
  assign e1_alarm   = oh_regs.ctrl.ra_per_frame ? oh_regs.ra[oh_pair] // see RULE17
                                                : oh_regs.naf[5]; // see RULE13
  assign e1_sa4     = oh_regs.ctrl.sa4_per_frame ? oh_regs.sa4[oh_pair] // see RULE18
                                                 : oh_regs.naf[4]; // see RULE14
  assign e1_word    = oh_frame[0] ?
                      {e1_si_odd, 1'b1, e1_alarm, e1_sa4, oh_regs.naf[3:0]} : // see RULE14
                      {e1_si_even, oh_regs.af[6:0]}; // see RULE11

  // Forcing the fixed switching bits here keeps the line legal even if
  // software writes them wrong.
  assign slc_vec = {fix_slc3(oh_regs.slc3), fix_slc2(oh_regs.slc2), // see RULE19
                    oh_regs.slc1};
  assign slc_bit = (OH_REQ.idx < SLC_BITS) ? slc_vec[OH_REQ.idx] : 1'b0;

  always_comb begin
    next_oh_data = RST_ZERO;
    unique case (OH_REQ.kind)
      OH_FDL: begin
        next_oh_data = oh_e1 ? RST_ZERO : {7'h00, fdl_bit[OH_REQ.port]};
      end
      OH_BOC: begin
        next_oh_data = oh_e1 ? RST_ZERO : (oh_regs.boc & BOC_MASK); // see RULE8
      end
      OH_SLC: begin
        next_oh_data = oh_e1 ? RST_ZERO : {7'h00, slc_bit};
      end
      OH_E1: begin
        next_oh_data = oh_e1 ? e1_word : RST_ZERO; // see RULE10
      end
    endcase
  end

  // ************************************************************
  // Output registers
  // ************************************************************
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= next_pready;
      PRDATA  <= (next_pready && !PWRITE && addr_ok) ? {24'h00_0000, rd_data}
                                                     : 32'h0000_0000;
      PSLVERR <= next_pready && !addr_ok;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      CH_OUT_VALID <= 1'b0;
      CH_OUT       <= '0;
      OH_ACK       <= 1'b0;
      OH_DATA      <= RST_ZERO;
    end else begin
      CH_OUT_VALID <= CH_IN_VALID;
      CH_OUT       <= CH_IN_VALID ? next_ch : CH_OUT;
      OH_ACK       <= OH_REQ_VALID;
      // Answers hold between requests to save toggling.
      OH_DATA      <= OH_REQ_VALID ? next_oh_data : OH_DATA;
    end
  end

endmodule : tos_tx_overhead

// ==== testbench/tos_tx_overhead_asserts.sv ====
`timescale 1ns/1ns
module tos_chk
  import tos_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        SRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic        PSLVERR,
  input wire logic        CH_IN_VALID,
  input wire tos_chan_t   CH_IN,
  input wire logic        CH_OUT_VALID,
  input wire tos_chan_t   CH_OUT,
  input wire logic        OH_REQ_VALID,
  input wire tos_oh_req_t OH_REQ,
  input wire logic        OH_ACK,
  input wire logic [7:0]  OH_DATA
);
  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_access;
    PSEL && PENABLE;
  endsequence
  a_ready_latency: assert property (s_setup ##1 s_access |=> PREADY)
    else $error("ready late");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready too long");
  a_err_read_zero: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error response malformed");
  a_rdata_byte: assert property (PRDATA[31:8] == 24'h0 && (PREADY || PRDATA == 32'h0))
    else $error("read data outside byte or cycle");
  a_chan_follow: assert property (CH_IN_VALID |=> CH_OUT_VALID
    && CH_OUT.num == $past(CH_IN.num) && CH_OUT.port == $past(CH_IN.port))
    else $error("channel output lost");
  a_chan_idle: assert property (!CH_IN_VALID |=> !CH_OUT_VALID && $stable(CH_OUT))
    else $error("channel output moved");
  a_oh_follow: assert property (OH_REQ_VALID |=> OH_ACK)
    else $error("overhead ack missing");
  a_oh_idle: assert property (!OH_REQ_VALID |=> !OH_ACK && $stable(OH_DATA))
    else $error("overhead answer moved");
  a_code_width: assert property (OH_REQ_VALID && OH_REQ.kind == OH_BOC |=>
    OH_DATA[7:6] == 2'h0) else $error("bit code too wide");
  a_odd_fixed: assert property (OH_REQ_VALID && OH_REQ.kind == OH_E1 && OH_REQ.idx[0]
    |=> OH_DATA[6] || OH_DATA == 8'h0) else $error("fixed one missing");
endmodule : tos_chk

bind tos_tx_overhead tos_chk i_tos_chk (
  .REF_CLK(REF_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .PRDATA(PRDATA), .PSLVERR(PSLVERR), .CH_IN_VALID(CH_IN_VALID), .CH_IN(CH_IN),
  .CH_OUT_VALID(CH_OUT_VALID), .CH_OUT(CH_OUT), .OH_REQ_VALID(OH_REQ_VALID),
  .OH_REQ(OH_REQ), .OH_ACK(OH_ACK), .OH_DATA(OH_DATA));

// ==== testbench/tos_line_model.sv ====
`timescale 1ns/1ns
module tos_line_model
  import tos_pkg::*;
(
  input  wire logic       clk,
  output logic            ch_in_valid,
  output tos_chan_t       ch_in,
  input  wire logic       ch_out_valid,
  input  wire tos_chan_t  ch_out,
  output logic            oh_req_valid,
  output tos_oh_req_t     oh_req,
  input  wire logic       oh_ack,
  input  wire logic [7:0] oh_data
);
  // ************************************************************
  // Line side requester
  // ************************************************************
  initial begin
    ch_in_valid = 1'b0;
    ch_in = '0;
    oh_req_valid = 1'b0;
    oh_req = '0;
  end
  // Released fields are inverted so a stale value is never mistaken for a request.
  task automatic oh(input tos_oh_kind_t k, input logic [2:0] p, input logic [4:0] i,
                    output logic [7:0] d, output logic a);
    oh_req_valid <= 1'b1;
    oh_req <= '{kind: k, port: p, idx: i};
    @(posedge clk);
    oh_req_valid <= 1'b0;
    oh_req <= tos_oh_req_t'(~oh_req);
    @(posedge clk);
    a = oh_ack;
    d = oh_data;
  endtask : oh
  task automatic chan(input logic [2:0] p, input logic [4:0] n, input logic [7:0] v,
                      output tos_chan_t o, output logic a);
    ch_in_valid <= 1'b1;
    ch_in <= '{port: p, num: n, data: v};
    @(posedge clk);
    ch_in_valid <= 1'b0;
    ch_in <= tos_chan_t'(~ch_in);
    @(posedge clk);
    a = ch_out_valid;
    o = ch_out;
  endtask : chan
endmodule : tos_line_model

// ==== testbench/tos_tx_overhead_test.sv ====
`timescale 1ns/1ns
module tos_tx_overhead_test
  import tos_pkg::*;
;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic        pready, pslverr, ch_in_valid, ch_out_valid, oh_req_valid, oh_ack;
  logic [31:0] prdata;
  logic [7:0]  oh_data;
  tos_chan_t   ch_in, ch_out;
  tos_oh_req_t oh_req;
  int          err_count = 0;
  int          check_count = 0;

  always #4 clk = ~clk;

  tos_tx_overhead i_tos_tx_overhead (
    .REF_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .CH_IN_VALID(ch_in_valid), .CH_IN(ch_in), .CH_OUT_VALID(ch_out_valid), .CH_OUT(ch_out),
    .OH_REQ_VALID(oh_req_valid), .OH_REQ(oh_req), .OH_ACK(oh_ack), .OH_DATA(oh_data));
  tos_line_model i_tos_line_model (
    .clk(clk), .ch_in_valid(ch_in_valid), .ch_in(ch_in), .ch_out_valid(ch_out_valid),
    .ch_out(ch_out), .oh_req_valid(oh_req_valid), .oh_req(oh_req), .oh_ack(oh_ack),
    .oh_data(oh_data));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [2:0] p, input logic [8:0] i, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, {2'h0, p, i, 2'h0}, d, r, e);
  endtask : wr
  task automatic rchk(input logic [2:0] p, input logic [8:0] i, input logic [7:0] x,
                      input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, {2'h0, p, i, 2'h0}, 8'h00, r, e);
    check(what, r, {24'h0, x});
    check({what, " error"}, {31'h0, e}, 32'h0);
  endtask : rchk
  task automatic ohx(input tos_oh_kind_t k, input logic [2:0] p, input logic [4:0] i,
                     output logic [7:0] d);
    logic a;
    i_tos_line_model.oh(k, p, i, d, a);
    check("overhead ack", {31'h0, a}, 32'h1);
  endtask : ohx

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    logic [7:0]  d;
    logic [31:0] r;
    logic        e;
    rchk(3'h0, OFS_FW_REV, FW_REV, "revision");
    wr(3'h0, OFS_FW_REV, 8'hA5);
    rchk(3'h0, OFS_FW_REV, FW_REV, "revision after write");
    rchk(3'h0, OFS_LINK1, RST_ZERO, "slc1 reset");
    wr(3'h0, OFS_BOC, 8'hFF);
    rchk(3'h0, OFS_BOC, BOC_MASK, "bit code");
    ohx(OH_BOC, 3'h0, 5'h0, d);
    check("bit code sent", {24'h0, d}, {24'h0, BOC_MASK});
    wr(3'h3, OFS_BOC, 8'h2A);
    rchk(3'h3, OFS_BOC, 8'h2A, "port 3 code");
    rchk(3'h7, OFS_BOC, RST_ZERO, "port 7 code");
    apb(1'b0, 16'h07FC, 8'h00, r, e);
    check("unmapped", {r[31:1], e}, 32'h1);
    apb(1'b1, 16'hC58C, 8'h11, r, e);
    check("high address", {31'h0, e}, 32'h1);
    rchk(3'h0, OFS_BOC, BOC_MASK, "code kept");
    $display("test regs done");
  endtask : t_regs
  task automatic t_e1();
    logic [7:0] d;
    logic [7:0] x;
    int         k;
    wr(3'h1, OFS_LINE_CTRL, 8'h01);
    rchk(3'h1, OFS_LINK1, RST_ALIGN, "align reset");
    rchk(3'h1, OFS_LINK2, RST_NONALIGN, "nonalign reset");
    wr(3'h1, OFS_LINK1, 8'h9B);
    wr(3'h1, OFS_LINK2, 8'hB5);
    rchk(3'h1, OFS_LINK2, 8'hF5, "nonalign fixed");
    ohx(OH_E1, 3'h1, 5'h0, d);
    check("align word", {24'h0, d}, 32'h9B);
    ohx(OH_E1, 3'h1, 5'h1, d);
    check("nonalign word", {24'h0, d}, 32'hF5);
    ohx(OH_BOC, 3'h1, 5'h0, d);
    check("t1 kind in e1", {24'h0, d}, 32'h0);
    wr(3'h1, OFS_LINK3, 8'h81);
    wr(3'h1, OFS_SI_ODD, 8'h02);
    wr(3'h1, OFS_RA, 8'h80);
    wr(3'h1, OFS_SA4, 8'h01);
    wr(3'h1, OFS_LINE_CTRL, 8'h39);
    for (int f = 0; f < 16; f++) begin
      k = f / 2;
      x = (f % 2 == 0) ? {1'(8'h81 >> k), 7'h1B}
                       : {1'(8'h02 >> k), 1'b1, 1'(8'h80 >> k), 1'(8'h01 >> k), 4'h5};
      ohx(OH_E1, 3'h1, 5'(f), d);
      check("frame word", {24'h0, d}, {24'h0, x});
    end
    $display("test e1 done");
  endtask : t_e1
  task automatic t_link();
    logic [7:0]  d;
    logic [23:0] v;
    wr(3'h2, OFS_FDL, 8'hB4);
    for (int b = 0; b < 8; b++) begin
      ohx(OH_FDL, 3'h2, 5'h0, d);
      check("link bit", {31'h0, d[0]}, {31'h0, 1'(8'hB4 >> b)});
    end
    wr(3'h2, OFS_LINE_CTRL, 8'h02);
    wr(3'h2, OFS_FDL, 8'hE5);
    for (int b = 0; b < 7; b++) begin
      ohx(OH_FDL, 3'h2, 5'h0, d);
      check("d4 bit", {31'h0, d[0]}, {31'h0, 1'(8'hE5 >> (b % 6))});
    end
    wr(3'h4, OFS_LINE_CTRL, 8'h04);
    wr(3'h4, OFS_LINK1, 8'hA5);
    rchk(3'h4, OFS_LINK2, SLC2_FIX_VAL, "slc2 fixed");
    rchk(3'h4, OFS_LINK3, SLC3_FIX_VAL, "slc3 fixed");
    v = {SLC3_FIX_VAL, SLC2_FIX_VAL, 8'hA5};
    for (int i = 0; i < 25; i++) begin
      ohx(OH_SLC, 3'h4, 5'(i), d);
      check("slc bit", {31'h0, d[0]}, {31'h0, (i < 24) && v[i]});
    end
    $display("test link done");
  endtask : t_link
  task automatic t_idle();
    tos_chan_t o;
    logic      a;
    wr(3'h5, OFS_IDLE_CODE + 9'h004, 8'hA5);
    wr(3'h5, OFS_INS_EN, 8'h10);
    wr(3'h5, OFS_IDLE_CODE + 9'h018, 8'h3C);
    wr(3'h5, OFS_INS_EN + 9'h003, 8'h01);
    i_tos_line_model.chan(3'h5, 5'h04, 8'h11, o, a);
    check("inserted", {24'h0, o.data}, 32'hA5);
    i_tos_line_model.chan(3'h5, 5'h03, 8'h22, o, a);
    check("passed", {23'h0, a, o.data}, 32'h122);
    i_tos_line_model.chan(3'h5, 5'h18, 8'h33, o, a);
    check("t1 top channel", {24'h0, o.data}, 32'h33);
    i_tos_line_model.chan(3'h6, 5'h04, 8'h44, o, a);
    check("other port", {24'h0, o.data}, 32'h44);
    wr(3'h5, OFS_LINE_CTRL, 8'h01);
    i_tos_line_model.chan(3'h5, 5'h18, 8'h33, o, a);
    check("e1 top channel", {24'h0, o.data}, 32'h3C);
    $display("test idle done");
  endtask : t_idle

  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_e1();
    t_link();
    t_idle();
    end_sim();
  end
endmodule : tos_tx_overhead_test
